// [rtl/hbm_pkg.sv]
// constants and types of the half-bridge on-time modulator
package hbm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 10;
  localparam int MIN_FREQ_HZ = 20000;
  localparam int MAX_ON_NS = 1000000000 / (2 * MIN_FREQ_HZ);
  localparam int MAX_ON_TICKS = MAX_ON_NS / TICK_NS;
  localparam int ACC_W = 5;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(TICK_NS);

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DEAD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_BLANK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ONTIME = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int TIME_W = 8;
  localparam logic [TIME_W-1:0] DEAD_RST = 8'h14;
  localparam logic [TIME_W-1:0] BLANK_RST = 8'h19;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_REPEAT_BIT = 4;
  localparam int ST_FF_BIT = 5;
  localparam int ST_PD_BIT = 6;
  localparam int ST_BYP_BIT = 7;
  localparam int ST_SS_BIT = 8;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    HBM_IDLE = 3'b000,
    HBM_GAP_LH = 3'b001,
    HBM_HIGH = 3'b010,
    HBM_GAP_HL = 3'b011,
    HBM_LOW = 3'b100
  } hbm_state_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } hbm_gate_t;

  typedef struct packed {
    logic pulldown_on;
    logic bypass_on;
    logic current_limit_on;
  } hbm_fse_t;

endpackage

// [rtl/hbm_sync2.sv]
// two-stage synchroniser for level inputs
`timescale 1ns/1ps
`default_nettype none
module hbm_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // hbm_sync2
`default_nettype wire

// [rtl/hbm_fse_ctrl.sv]
// front-stage enable output switch control
`timescale 1ns/1ps
`default_nettype none
module hbm_fse_ctrl
  import hbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic startup_done,
  input wire logic protection_mode,
  input wire logic self_supply_cycling,
  output hbm_fse_t fse
);
  logic pd_reg;
  logic pd_next;
  logic byp_reg;
  logic byp_next;
  logic want_low;

  always_comb begin
    want_low = !startup_done || (protection_mode && self_supply_cycling);
    pd_next = want_low && !byp_reg;
    byp_next = !want_low && !pd_reg;
  end

  // pull-down on from reset: supply still ramping
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_reg <= 1'b1;
      byp_reg <= 1'b0;
    end else begin
      pd_reg <= pd_next;
      byp_reg <= byp_next;
    end
  end

  assign fse.pulldown_on = pd_reg;
  assign fse.bypass_on = byp_reg;
  assign fse.current_limit_on = byp_reg;
endmodule // hbm_fse_ctrl
`default_nettype wire

// [rtl/hbm_modulator.sv]
// on-time modulator top: gate sequencing, blanking, repeat logic, registers
`timescale 1ns/1ps
`default_nettype none
module hbm_modulator
  import hbm_pkg::*;
#(
  parameter int ONTIME_W = 12,
  parameter int STUCK_CYCLES = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ontime_cmp,
  input wire logic startup_done,
  input wire logic soft_start_active,
  input wire logic protection_mode,
  input wire logic self_supply_cycling,
  input wire logic line_voltage_good,
  output hbm_gate_t gate,
  output logic softstart_override,
  output logic feedforward_current,
  output hbm_fse_t front_stage_enable_out
);

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (((1 << ONTIME_W) - 1) < MAX_ON_TICKS) begin : g_bad_w
      $error("on-time counter too narrow");
    end
    if (STUCK_CYCLES < 1 || STUCK_CYCLES > 15) begin : g_bad_stuck
      $error("stuck cycle count out of range");
    end
  endgenerate

  localparam logic [ONTIME_W-1:0] CNT_MAX = ONTIME_W'(MAX_ON_TICKS);
  localparam logic [3:0] STUCK_LIM = 4'(STUCK_CYCLES);

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic cmp_s;
  logic lvg_s;
  logic ss_s;

  assign sync_in = {ontime_cmp, line_voltage_good, soft_start_active};
  hbm_sync2 #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(sync_in),
    .q(sync_out)
  );
  assign cmp_s = sync_out[2];
  assign lvg_s = sync_out[1];
  assign ss_s = sync_out[0];

  hbm_fse_ctrl u_fse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .startup_done(startup_done),
    .protection_mode(protection_mode),
    .self_supply_cycling(self_supply_cycling),
    .fse(front_stage_enable_out)
  );

  // ****************************************
  // 10 ns tick from 8 ns clock
  // ****************************************
  // fractional divider: ticks average exactly 10 ns, jitter one clock
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic tick;

  always_comb begin
    acc_next = acc_reg + ACC_STEP;
    tick = 1'b0;
    if (acc_next >= ACC_WRAP) begin
      acc_next = acc_next - ACC_WRAP;
      tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic run_reg;
  logic run_next;
  logic [TIME_W-1:0] dead_reg;
  logic [TIME_W-1:0] dead_next;
  logic [TIME_W-1:0] blank_reg;
  logic [TIME_W-1:0] blank_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] status_word;

  hbm_state_t state_reg;
  hbm_state_t state_next;
  logic [ONTIME_W-1:0] cnt_reg;
  logic [ONTIME_W-1:0] cnt_next;
  logic [ONTIME_W-1:0] last_reg;
  logic [ONTIME_W-1:0] last_next;
  logic [TIME_W-1:0] tmr_reg;
  logic [TIME_W-1:0] tmr_next;
  logic [3:0] stuck_reg;
  logic [3:0] stuck_next;
  logic low_seen_reg;
  logic low_seen_next;
  logic ff_reg;
  logic ff_next;
  logic ss_reg;
  logic ss_next;
  hbm_gate_t gate_reg;
  hbm_gate_t gate_next;

  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = state_reg;
    status_word[ST_REPEAT_BIT] = (stuck_reg >= STUCK_LIM);
    status_word[ST_FF_BIT] = ff_reg;
    status_word[ST_PD_BIT] = front_stage_enable_out.pulldown_on;
    status_word[ST_BYP_BIT] = front_stage_enable_out.bypass_on;
    status_word[ST_SS_BIT] = ss_reg;
  end

  always_comb begin
    run_next = run_reg;
    dead_next = dead_reg;
    blank_next = blank_reg;
    rdata_next = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          run_next = reg_wdata[CTRL_RUN_BIT];
        end
        REG_DEAD: begin
          dead_next = reg_wdata[TIME_W-1:0];
        end
        REG_BLANK: begin
          blank_next = reg_wdata[TIME_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_next = {31'h0, run_reg};
        REG_DEAD: rdata_next = {24'h0, dead_reg};
        REG_BLANK: rdata_next = {24'h0, blank_reg};
        REG_STATUS: rdata_next = status_word;
        REG_ONTIME: rdata_next = {{(32-ONTIME_W){1'b0}}, last_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      dead_reg <= DEAD_RST;
      blank_reg <= BLANK_RST;
      rdata_reg <= '0;
    end else begin
      run_reg <= run_next;
      dead_reg <= dead_next;
      blank_reg <= blank_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // modulation sequencer
  // ****************************************
  logic go;
  logic repeat_mode;
  logic blanked;
  logic hi_end;

  assign go = run_reg && startup_done && !protection_mode;
  assign repeat_mode = (stuck_reg >= STUCK_LIM);
  assign blanked = (tmr_reg < blank_reg);

  always_comb begin
    hi_end = 1'b0;
    if (!blanked) begin
      if (repeat_mode) begin
        hi_end = (cnt_reg >= last_reg);
      end else begin
        hi_end = cmp_s;
      end
    end
    if (cnt_reg >= CNT_MAX) begin
      hi_end = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    last_next = last_reg;
    tmr_next = tmr_reg;
    stuck_next = stuck_reg;
    low_seen_next = low_seen_reg || !cmp_s;
    gate_next = '0;
    case (state_reg)
      HBM_IDLE: begin
        tmr_next = '0;
        cnt_next = '0;
        if (go) begin
          state_next = HBM_GAP_LH;
        end
      end
      HBM_GAP_LH: begin
        if (tick) begin
          tmr_next = tmr_reg + 1'b1;
        end
        if (!go) begin
          state_next = HBM_IDLE;
        end else if (tmr_reg >= dead_reg) begin
          state_next = HBM_HIGH;
          gate_next.hs_on = 1'b1;
          tmr_next = '0;
          cnt_next = '0;
          low_seen_next = !cmp_s;
        end
      end
      HBM_HIGH: begin
        gate_next.hs_on = 1'b1;
        if (tick && blanked) begin
          tmr_next = tmr_reg + 1'b1;
        end
        if (!go) begin
          state_next = HBM_GAP_HL;
          gate_next.hs_on = 1'b0;
          tmr_next = '0;
        end else if (hi_end) begin
          state_next = HBM_GAP_HL;
          gate_next.hs_on = 1'b0;
          tmr_next = '0;
          // comparator never low: pulse ended by blanking, not a valid on-time
          if (!repeat_mode && low_seen_reg && cnt_reg != '0) begin
            last_next = cnt_reg;
          end
        end else if (tick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      HBM_GAP_HL: begin
        if (tick) begin
          tmr_next = tmr_reg + 1'b1;
        end
        if (!go) begin
          state_next = HBM_IDLE;
        end else if (tmr_reg >= dead_reg) begin
          state_next = HBM_LOW;
          gate_next.ls_on = (cnt_reg != '0);
          tmr_next = '0;
        end
      end
      HBM_LOW: begin
        gate_next.ls_on = 1'b1;
        if (!go || cnt_reg == '0) begin
          state_next = HBM_GAP_LH;
          gate_next.ls_on = 1'b0;
          tmr_next = '0;
          if (low_seen_reg) begin
            stuck_next = '0;
          end else if (stuck_reg < STUCK_LIM) begin
            stuck_next = stuck_reg + 1'b1;
          end
        end else if (tick) begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == {{(ONTIME_W-1){1'b0}}, 1'b1}) begin
            gate_next.ls_on = 1'b0;
          end
        end
      end
      default: begin
        state_next = HBM_IDLE;
      end
    endcase
    if (gate_next.hs_on) begin
      gate_next.ls_on = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HBM_IDLE;
      cnt_reg <= '0;
      last_reg <= '0;
      tmr_reg <= '0;
      stuck_reg <= '0;
      low_seen_reg <= 1'b0;
      gate_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      last_reg <= last_next;
      tmr_reg <= tmr_next;
      stuck_reg <= stuck_next;
      low_seen_reg <= low_seen_next;
      gate_reg <= gate_next;
    end
  end

  assign gate = gate_reg;

  // ****************************************
  // set point select and feed-forward gate
  // ****************************************
  always_comb begin
    ss_next = ss_s || !startup_done;
    ff_next = lvg_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ss_reg <= 1'b1;
      ff_reg <= 1'b0;
    end else begin
      ss_reg <= ss_next;
      ff_reg <= ff_next;
    end
  end

  assign softstart_override = ss_reg;
  assign feedforward_current = ff_reg;

endmodule // hbm_modulator
`default_nettype wire

// [tb/hbm_modulator_sva.sv]
// concurrent checks on the on-time modulator ports
`timescale 1ns/1ps
`default_nettype none
module hbm_modulator_sva
  import hbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ontime_cmp,
  input wire logic startup_done,
  input wire logic soft_start_active,
  input wire logic protection_mode,
  input wire logic self_supply_cycling,
  input wire logic line_voltage_good,
  input wire hbm_gate_t gate,
  input wire logic softstart_override,
  input wire logic feedforward_current,
  input wire hbm_fse_t front_stage_enable_out
);
  // ****************************************
  // pulse length counters
  // ****************************************
  logic go_in;
  logic [11:0] off_reg, off_next, hs_reg, hs_next, hsl_reg, hsl_next, ls_reg, ls_next;
  assign go_in = startup_done && !protection_mode;
  // off count saturates so a long idle never wraps to a short gap
  always_comb begin
    off_next = (gate.hs_on || gate.ls_on) ? 12'h000 : off_reg + {11'h000, off_reg != 12'hfff};
    hs_next = gate.hs_on ? hs_reg + 12'h001 : 12'h000;
    hsl_next = (!gate.hs_on && hs_reg != 12'h000) ? hs_reg : hsl_reg;
    ls_next = gate.ls_on ? ls_reg + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      off_reg <= 12'h000;
      hs_reg <= 12'h000;
      hsl_reg <= 12'h000;
      ls_reg <= 12'h000;
    end else begin
      off_reg <= off_next;
      hs_reg <= hs_next;
      hsl_reg <= hsl_next;
      ls_reg <= ls_next;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // 20 ticks of 10 ns is 25 clocks; tick jitter allows two less
  chk_no_overlap: assert property (!(gate.hs_on && gate.ls_on))
    else $error("high and low switch on together");
  chk_gap_high: assert property ($rose(gate.hs_on) |-> off_reg >= 12'h017)
    else $error("high side on before gap elapsed");
  chk_gap_low: assert property ($rose(gate.ls_on) |-> off_reg >= 12'h017)
    else $error("low side on before gap elapsed");
  chk_blank_hold: assert property ($fell(gate.hs_on) && go_in && $past(go_in) |-> hs_reg >= 12'h01e)
    else $error("high pulse shorter than blanking");
  chk_low_match: assert property ($fell(gate.ls_on) && go_in && $past(go_in)
    |-> ls_reg + 12'h002 >= hsl_reg && ls_reg <= hsl_reg + 12'h002)
    else $error("low pulse differs from high pulse");
  chk_cmp_end: assert property (gate.hs_on && hs_reg > 12'h022 && $rose(ontime_cmp)
    |-> ##[1:6] !gate.hs_on)
    else $error("comparator did not end high pulse");
  chk_ff_off: assert property (!line_voltage_good [*4] |-> !feedforward_current)
    else $error("feed-forward on without line good");
  chk_ff_on: assert property (line_voltage_good [*4] |-> feedforward_current)
    else $error("feed-forward off with line good");
  chk_pd_hold: assert property ((!startup_done || (protection_mode && self_supply_cycling)) [*3]
    |-> front_stage_enable_out.pulldown_on)
    else $error("enable output not pulled down");
  chk_pd_excl: assert property (!(front_stage_enable_out.pulldown_on && front_stage_enable_out.bypass_on))
    else $error("pull-down and bypass on together");
  chk_limit_byp: assert property (front_stage_enable_out.current_limit_on == front_stage_enable_out.bypass_on)
    else $error("current limit not tied to bypass");
  chk_ss_over: assert property ((soft_start_active || !startup_done) [*4] |-> softstart_override)
    else $error("soft-start override missing");
  cover property ($fell(gate.ls_on));
  cover property ($rose(front_stage_enable_out.bypass_on));
  cover property ($rose(feedforward_current));
endmodule // hbm_modulator_sva

bind hbm_modulator hbm_modulator_sva i_hbm_modulator_sva (.clk_sys, .rst_n, .ontime_cmp,
  .startup_done, .soft_start_active, .protection_mode, .self_supply_cycling,
  .line_voltage_good, .gate, .softstart_override, .feedforward_current, .front_stage_enable_out);
`default_nettype wire

// [tb/hbm_ramp_model.sv]
// sense ramp and comparator stand-in facing the switch outputs
`timescale 1ns/1ps
`default_nettype none
module hbm_ramp_model
  import hbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire hbm_gate_t gate,
  input wire logic [11:0] trip,
  input wire logic stuck,
  output logic ontime_cmp
);
  logic [11:0] ramp_reg, ramp_next;
  logic cmp_next;
  always_comb begin
    ramp_next = gate.hs_on ? ramp_reg + 12'h001 : 12'h000;
    cmp_next = stuck || (gate.hs_on && ramp_reg >= trip);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_reg <= 12'h000;
      ontime_cmp <= 1'b0;
    end else begin
      ramp_reg <= ramp_next;
      ontime_cmp <= cmp_next;
    end
  end
endmodule // hbm_ramp_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the on-time modulator
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import hbm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, ontime_cmp, startup_done, soft_start_active, protection_mode;
  logic self_supply_cycling, line_voltage_good, softstart_override, feedforward_current, stuck;
  logic rd_d = 1'b0;
  logic [11:0] trip;
  hbm_gate_t gate;
  hbm_fse_t front_stage_enable_out;
  int errors = 0;
  int checks_done = 0;
  int seed = 36207;
  int hs_n = 0;
  int falls = 0;
  int last_trip;
  logic [31:0] q_rd[$];
  logic [31:0] q_mask[$];
  int q_len[$];

  hbm_modulator i_hbm_modulator (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ontime_cmp, .startup_done, .soft_start_active, .protection_mode,
    .self_supply_cycling, .line_voltage_good, .gate, .softstart_override,
    .feedforward_current, .front_stage_enable_out);
  hbm_ramp_model i_hbm_ramp_model (.clk_sys, .rst_n, .gate, .trip, .stuck, .ontime_cmp);

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check_rd(input logic [31:0] e, input logic [31:0] m, input logic [31:0] s);
    checks_done++;
    if ((s & m) !== e) begin
      errors++;
      $display("CHECK FAILED reg_rdata expected %h seen %h", e, s & m);
    end
  endtask
  // tick jitter makes lengths exact only to two clocks
  task automatic check_len(input int e, input int s);
    checks_done++;
    if (s < e - 2 || s > e + 2) begin
      errors++;
      $display("CHECK FAILED hs_on cycles expected %0d seen %0d", e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q_rd.push_back(e);
    q_mask.push_back(m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_falls(input int n);
    int target;
    target = falls + n;
    for (int i = 0; i < 20000 && falls < target; i++) @(posedge clk_sys);
    if (falls < target) begin
      errors++;
      $display("CHECK FAILED hs_on pulses expected %0d seen %0d", target, falls);
      results();
    end
  endtask

  // ****************************************
  // output watcher
  // ****************************************
  always @(posedge clk_sys) begin
    if (rd_d) check_rd(q_rd.pop_front(), q_mask.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    if (gate.hs_on === 1'b1) hs_n++;
    else if (hs_n > 0) begin
      if (q_len.size() > 0) check_len(q_len.pop_front(), hs_n);
      hs_n = 0;
      falls++;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    startup_done = 1'b0;
    soft_start_active = 1'b1;
    protection_mode = 1'b0;
    self_supply_cycling = 1'b0;
    line_voltage_good = 1'b0;
    trip = 12'h040;
    stuck = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_CTRL, 32'h0, 32'hffffffff);
    rd(REG_DEAD, {24'h0, DEAD_RST}, 32'hffffffff);
    rd(REG_BLANK, {24'h0, BLANK_RST}, 32'hffffffff);
    wr(8'h20, $random(seed));
    rd(8'h20, 32'h0, 32'hffffffff);
    rd(REG_STATUS, 32'h140, 32'h1e0);
    wr(REG_DEAD, ($random(seed) & 32'hffffff00) | 32'h33);
    rd(REG_DEAD, 32'h33, 32'hffffffff);
    wr(REG_DEAD, {24'h0, DEAD_RST});
    rd(REG_DEAD, {24'h0, DEAD_RST}, 32'hffffffff);
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1, 32'hffffffff);
    $display("test registers done");
    startup_done <= 1'b1;
    soft_start_active <= 1'b0;
    line_voltage_good <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(REG_STATUS, 32'h0a0, 32'h1e0);
    $display("test front stage done");
    wait_falls(1);
    for (int k = 0; k < 8; k++) begin
      last_trip = 40 + ($random(seed) & 127);
      trip <= 12'(last_trip);
      q_len.push_back(last_trip + 4);
      wait_falls(1);
    end
    $display("test on-time done");
    rd(REG_ONTIME, 32'h0, 32'hffffff00);
    stuck <= 1'b1;
    wait_falls(2);
    repeat (2) begin
      q_len.push_back(last_trip + 4);
      wait_falls(1);
    end
    rd(REG_STATUS, 32'h10, 32'h10);
    stuck <= 1'b0;
    wait_falls(2);
    $display("test repeat done");
    protection_mode <= 1'b1;
    self_supply_cycling <= 1'b1;
    line_voltage_good <= 1'b0;
    repeat (60) @(posedge clk_sys);
    rd(REG_STATUS, 32'h040, 32'h0e7);
    rd(REG_STATUS, 32'h0, 32'h110);
    $display("test protection done");
    results();
  end
endmodule // tb_top
`default_nettype wire
